// *** verilog/seq_defines.svh ***
// Register offsets, reset values and timing constants of the output sequencer
`ifndef SEQ_DEFINES_SVH
`define SEQ_DEFINES_SVH

`define CMD_UV_FAULT_LIMIT 8'h59
`define CMD_UV_RESPONSE 8'h5A
`define CMD_PG_THRESHOLD 8'h5E
`define CMD_TURN_ON_DELAY 8'h60
`define CMD_TURN_ON_RAMP 8'h61
`define CMD_TURN_OFF_DELAY 8'h64

`define RST_UV_RESPONSE 8'h80
`define RST_TIME_WORD 16'hCA80
`define RST_PG_THRESHOLD 16'h0000

`define RESP_MODE_HI 7
`define RESP_MODE_LO 6
`define RESP_RETRY_HI 5
`define RESP_RETRY_LO 3
`define RESP_MODE_DISABLE 2'h2
`define RESP_RETRY_NONE 3'h0
`define RESP_RETRY_FOREVER 3'h7

`define CLK_FREQ_HZ 50000000
`define CYC_PER_MS (`CLK_FREQ_HZ / 1000)
`define RETRY_TIME_MS 70
`define RETRY_CYCLES (`RETRY_TIME_MS * `CYC_PER_MS)
`define MAX_DELAY_MS 5000
`define MAX_DELAY_CYCLES (`MAX_DELAY_MS * `CYC_PER_MS)

`define PHASE_MODE_TWO 2'h0

`endif

// *** verilog/seq_pkg.sv ***
// Types shared by the output sequencer files
package seq_pkg;

    typedef enum logic [2:0] {
        ST_OFF,
        ST_ON_DELAY,
        ST_RAMP,
        ST_ON,
        ST_OFF_DELAY,
        ST_FAULT_HOLD,
        ST_RETRY_WAIT
    } seq_state_t;

    typedef struct packed {
        logic wr_en;
        logic [7:0] code;
        logic [15:0] data;
    } cmd_write_t;

    typedef struct packed {
        logic output_enable;
        logic ramp_start;
        logic fall_start;
        logic power_good;
        logic off;
    } seq_status_t;

endpackage

// *** verilog/linear11_cycles.sv ***
// Converts an exponent-mantissa time word in ms to a clock cycle count
`timescale 1ns/1ps
module linear11_cycles #(
    parameter int CYC_PER_MS = 50000,
    parameter logic [31:0] MAX_CYCLES = 32'd250000000
) (
    input wire logic [15:0] word,
    output logic [31:0] cycles
);
    logic signed [4:0] expo;
    logic signed [10:0] mant;
    logic [47:0] prod;
    logic [47:0] shifted;

    assign expo = word[15:11];
    assign mant = word[10:0];

    always_comb begin
        prod = 48'(mant[9:0]) * 48'(CYC_PER_MS);
        if (expo < 0) begin
            shifted = prod >> (-expo);
        end else begin
            shifted = prod << expo;
        end
        // Negative times are treated as zero; long values saturate at the limit
        if (mant < 0) begin
            cycles = 32'h0;
        end else if (shifted > 48'(MAX_CYCLES)) begin
            cycles = MAX_CYCLES;
        end else begin
            cycles = shifted[31:0];
        end
    end
endmodule

// *** verilog/output_sequencing_uv_response.sv ***
// Output sequencing, power-good and input-undervoltage response logic
`timescale 1ns/1ps
`include "seq_defines.svh"

// Summary of operation
// - The one-byte undervoltage response register resets to 80h, shutdown with no retry.
// - Response code 10 in bits 7:6 disables the output and applies the retry policy.
// - An undervoltage fault pulls the alert low and latches a fault bit cleared only by clear-faults.
// - Retry code 000 keeps the output off until the fault has been cleared.
// - Retry code 111 restarts without limit until commanded off or another fault stops it.
// - Restart attempts are spaced a fixed 70 ms apart and bits 2:0 are ignored.
// - Power-good sets above the power-good threshold and clears below the output UV fault limit or while the output is disabled.
// - After enable the device waits the turn-on delay before starting the ramp.
// - After disable the device waits the turn-off delay before starting the fall.
// - Turn-on and turn-off delays are confined to the range zero to five seconds.
// - Turn-on delay, rise time and turn-off delay reset to CA80h, which is 5 ms.
// - Rise time governs the ramp only in two-phase mode, otherwise the ramp-gain setting does.
// - Time words are decoded as signed exponent over signed mantissa, value Y times 2 to the N.
// - The UV fault threshold uses the same encoding and resets from the pin-strap value.
module output_sequencing_uv_response #(
    parameter int CYC_PER_MS = `CYC_PER_MS,
    parameter logic [31:0] RETRY_CYCLES = `RETRY_CYCLES,
    parameter logic [31:0] MAX_DELAY_CYCLES = `MAX_DELAY_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire seq_pkg::cmd_write_t cmd_wr,
    input wire logic [7:0] rd_code,
    output logic [15:0] rd_data,
    output logic rd_valid,
    input wire logic clear_faults,
    input wire logic operation_on,
    input wire logic control_pin,
    input wire logic vin_uv_pin,
    input wire logic other_fault,
    input wire logic [15:0] uv_limit_strap,
    input wire logic [15:0] vout_level,
    input wire logic [15:0] vout_uv_limit,
    input wire logic [1:0] phase_mode,
    input wire logic [31:0] multi_ramp_cycles,
    output logic [15:0] uv_fault_limit,
    output seq_pkg::seq_status_t status,
    output logic [31:0] ramp_cycles,
    output logic alert_output_n,
    output logic uv_fault_status
);
    logic [7:0] uv_response_ff;
    logic [15:0] uv_limit_ff;
    logic [15:0] pg_threshold_ff;
    logic [15:0] on_delay_ff;
    logic [15:0] on_ramp_ff;
    logic [15:0] off_delay_ff;
    logic strap_loaded_ff;
    logic [15:0] rd_data_ff;
    logic rd_valid_ff;
    logic ctrl_meta_ff;
    logic ctrl_sync_ff;
    logic uv_meta_ff;
    logic uv_sync_ff;
    logic uv_fault_ff;
    logic alert_n_ff;
    logic power_good_ff;
    logic output_en_ff;
    logic ramp_start_ff;
    logic fall_start_ff;
    logic [31:0] timer_ff;
    logic [31:0] ramp_cycles_ff;
    logic [31:0] nxt_timer;
    logic [31:0] on_delay_cyc;
    logic [31:0] on_ramp_cyc;
    logic [31:0] off_delay_cyc;
    logic enabled;
    logic uv_event;
    logic timer_done;
    logic retry_forever;
    seq_pkg::seq_state_t state_ff;
    seq_pkg::seq_state_t nxt_state;

    // Time words to cycle counts, saturated at five seconds
    linear11_cycles #(.CYC_PER_MS(CYC_PER_MS), .MAX_CYCLES(MAX_DELAY_CYCLES)) u_on_delay (
        .word(on_delay_ff),
        .cycles(on_delay_cyc)
    );
    linear11_cycles #(.CYC_PER_MS(CYC_PER_MS), .MAX_CYCLES(MAX_DELAY_CYCLES)) u_on_ramp (
        .word(on_ramp_ff),
        .cycles(on_ramp_cyc)
    );
    linear11_cycles #(.CYC_PER_MS(CYC_PER_MS), .MAX_CYCLES(MAX_DELAY_CYCLES)) u_off_delay (
        .word(off_delay_ff),
        .cycles(off_delay_cyc)
    );

    // Pin inputs pass two flops before use
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_meta_ff <= 1'b0;
            ctrl_sync_ff <= 1'b0;
            uv_meta_ff <= 1'b0;
            uv_sync_ff <= 1'b0;
        end else begin
            ctrl_meta_ff <= control_pin;
            ctrl_sync_ff <= ctrl_meta_ff;
            uv_meta_ff <= vin_uv_pin;
            uv_sync_ff <= uv_meta_ff;
        end
    end

    assign enabled = ctrl_sync_ff & operation_on;
    assign uv_event = uv_sync_ff;
    assign retry_forever =
        (uv_response_ff[`RESP_RETRY_HI:`RESP_RETRY_LO] == `RESP_RETRY_FOREVER);
    assign timer_done = (timer_ff == 32'h0);

    // Command registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            uv_response_ff <= `RST_UV_RESPONSE;
            pg_threshold_ff <= `RST_PG_THRESHOLD;
            on_delay_ff <= `RST_TIME_WORD;
            on_ramp_ff <= `RST_TIME_WORD;
            off_delay_ff <= `RST_TIME_WORD;
        end else if (cmd_wr.wr_en) begin
            case (cmd_wr.code)
                `CMD_UV_RESPONSE: uv_response_ff <= cmd_wr.data[7:0];
                `CMD_PG_THRESHOLD: pg_threshold_ff <= cmd_wr.data;
                `CMD_TURN_ON_DELAY: on_delay_ff <= cmd_wr.data;
                `CMD_TURN_ON_RAMP: on_ramp_ff <= cmd_wr.data;
                `CMD_TURN_OFF_DELAY: off_delay_ff <= cmd_wr.data;
                default: ;
            endcase
        end
    end

    // Strap is caught after reset release, never inside the reset branch
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_loaded_ff <= 1'b0;
            uv_limit_ff <= 16'h0000;
        end else if (!strap_loaded_ff) begin
            strap_loaded_ff <= 1'b1;
            uv_limit_ff <= uv_limit_strap;
        end else if (cmd_wr.wr_en && cmd_wr.code == `CMD_UV_FAULT_LIMIT) begin
            uv_limit_ff <= cmd_wr.data;
        end
    end

    // Read port, one cycle latency; unknown codes read zero with valid low
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_ff <= 16'h0000;
            rd_valid_ff <= 1'b0;
        end else begin
            rd_valid_ff <= 1'b1;
            case (rd_code)
                `CMD_UV_FAULT_LIMIT: rd_data_ff <= uv_limit_ff;
                `CMD_UV_RESPONSE: rd_data_ff <= {8'h00, uv_response_ff};
                `CMD_PG_THRESHOLD: rd_data_ff <= pg_threshold_ff;
                `CMD_TURN_ON_DELAY: rd_data_ff <= on_delay_ff;
                `CMD_TURN_ON_RAMP: rd_data_ff <= on_ramp_ff;
                `CMD_TURN_OFF_DELAY: rd_data_ff <= off_delay_ff;
                default: begin
                    rd_data_ff <= 16'h0000;
                    rd_valid_ff <= 1'b0;
                end
            endcase
        end
    end

    // Fault latch: a new event wins over clear-faults in the same cycle
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            uv_fault_ff <= 1'b0;
            alert_n_ff <= 1'b1;
        end else if (uv_event) begin
            uv_fault_ff <= 1'b1;
            alert_n_ff <= 1'b0;
        end else if (clear_faults) begin
            uv_fault_ff <= 1'b0;
            alert_n_ff <= 1'b1;
        end
    end

    // Power-good with hysteresis against the output UV fault limit
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            power_good_ff <= 1'b0;
        end else if (!output_en_ff) begin
            power_good_ff <= 1'b0;
        end else if (vout_level > pg_threshold_ff) begin
            power_good_ff <= 1'b1;
        end else if (vout_level < vout_uv_limit) begin
            power_good_ff <= 1'b0;
        end
    end

    // Sequencer next state
    always_comb begin
        nxt_state = state_ff;
        nxt_timer = (timer_ff == 32'h0) ? 32'h0 : timer_ff - 32'h1;
        // Unused response codes still shut down: safer than ignoring a brown-out
        if (uv_event && state_ff != seq_pkg::ST_FAULT_HOLD
                && state_ff != seq_pkg::ST_RETRY_WAIT) begin
            if (retry_forever) begin
                nxt_state = seq_pkg::ST_RETRY_WAIT;
                nxt_timer = RETRY_CYCLES;
            end else begin
                nxt_state = seq_pkg::ST_FAULT_HOLD;
            end
        end else begin
            case (state_ff)
                seq_pkg::ST_OFF: begin
                    if (enabled && !uv_fault_ff) begin
                        nxt_state = seq_pkg::ST_ON_DELAY;
                        nxt_timer = on_delay_cyc;
                    end
                end
                seq_pkg::ST_ON_DELAY: begin
                    if (!enabled) begin
                        nxt_state = seq_pkg::ST_OFF;
                    end else if (timer_done) begin
                        nxt_state = seq_pkg::ST_RAMP;
                        nxt_timer = ramp_cycles_ff;
                    end
                end
                seq_pkg::ST_RAMP: begin
                    if (!enabled) begin
                        nxt_state = seq_pkg::ST_OFF_DELAY;
                        nxt_timer = off_delay_cyc;
                    end else if (timer_done) begin
                        nxt_state = seq_pkg::ST_ON;
                    end
                end
                seq_pkg::ST_ON: begin
                    if (!enabled) begin
                        nxt_state = seq_pkg::ST_OFF_DELAY;
                        nxt_timer = off_delay_cyc;
                    end
                end
                seq_pkg::ST_OFF_DELAY: begin
                    if (timer_done) begin
                        nxt_state = seq_pkg::ST_OFF;
                    end
                end
                seq_pkg::ST_FAULT_HOLD: begin
                    if (!uv_fault_ff) begin
                        nxt_state = seq_pkg::ST_OFF;
                    end
                end
                seq_pkg::ST_RETRY_WAIT: begin
                    if (!enabled || other_fault) begin
                        nxt_state = seq_pkg::ST_OFF;
                    end else if (timer_done && !uv_event) begin
                        nxt_state = seq_pkg::ST_ON_DELAY;
                        nxt_timer = on_delay_cyc;
                    end else if (timer_done) begin
                        nxt_timer = RETRY_CYCLES;
                    end
                end
                default: nxt_state = seq_pkg::ST_OFF;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= seq_pkg::ST_OFF;
            timer_ff <= 32'h0;
        end else begin
            state_ff <= nxt_state;
            timer_ff <= nxt_timer;
        end
    end

    // Ramp length chosen per phase configuration
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ramp_cycles_ff <= 32'h0;
        end else if (phase_mode == `PHASE_MODE_TWO) begin
            ramp_cycles_ff <= on_ramp_cyc;
        end else begin
            ramp_cycles_ff <= multi_ramp_cycles;
        end
    end

    // Power stage controls
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            output_en_ff <= 1'b0;
            ramp_start_ff <= 1'b0;
            fall_start_ff <= 1'b0;
        end else begin
            output_en_ff <= (nxt_state == seq_pkg::ST_RAMP) || (nxt_state == seq_pkg::ST_ON)
                || (nxt_state == seq_pkg::ST_OFF_DELAY);
            ramp_start_ff <= (state_ff == seq_pkg::ST_ON_DELAY)
                && (nxt_state == seq_pkg::ST_RAMP);
            fall_start_ff <= (state_ff == seq_pkg::ST_OFF_DELAY)
                && (nxt_state == seq_pkg::ST_OFF);
        end
    end

    assign rd_data = rd_data_ff;
    assign rd_valid = rd_valid_ff;
    assign uv_fault_limit = uv_limit_ff;
    assign ramp_cycles = ramp_cycles_ff;
    assign alert_output_n = alert_n_ff;
    assign uv_fault_status = uv_fault_ff;
    assign status.output_enable = output_en_ff;
    assign status.ramp_start = ramp_start_ff;
    assign status.fall_start = fall_start_ff;
    assign status.power_good = power_good_ff;
    assign status.off = ~output_en_ff;
endmodule

// *** verif/seq_host.sv ***
// Host model issuing command writes and reads to the sequencer
`timescale 1ns/1ps
module seq_host (
    input wire logic core_clk,
    input wire logic [15:0] rd_data,
    input wire logic rd_valid,
    output seq_pkg::cmd_write_t cmd_wr,
    output logic [7:0] rd_code
);
    initial begin
        cmd_wr = '0;
        rd_code = 8'h00;
    end
    // One-cycle write strobe, whole word per write
    task automatic wr(input logic [7:0] c, input logic [15:0] w);
        @(posedge core_clk) cmd_wr <= '{1'b1, c, w};
        @(posedge core_clk) cmd_wr.wr_en <= 1'b0;
    endtask
    // Read answer is taken one cycle after the code is driven, once the sampling edge has registered it
    task automatic rd(input logic [7:0] c, output logic [15:0] d, output logic v);
        @(posedge core_clk) rd_code <= c;
        @(posedge core_clk);
        #1;
        d = rd_data;
        v = rd_valid;
    endtask
endmodule

// *** verif/seq_chk.sv ***
// Port checker of the output sequencer
`timescale 1ns/1ps
module seq_chk #(
    parameter int CYC_PER_MS = 4,
    parameter logic [31:0] RETRY_CYCLES = 32'h32,
    parameter logic [31:0] MAX_DELAY_CYCLES = 32'h4E20
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clear_faults,
    input wire logic [15:0] vout_level,
    input wire logic [15:0] vout_uv_limit,
    input wire seq_pkg::seq_status_t status,
    input wire logic alert_output_n,
    input wire logic uv_fault_status
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic [31:0] off_cnt_ff;
    // Saturates so a long off time never wraps to a small count
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) off_cnt_ff <= 32'h0;
        else if ($fell(status.output_enable)) off_cnt_ff <= 32'h0;
        else if (off_cnt_ff != 32'hFFFFFFFF) off_cnt_ff <= off_cnt_ff + 32'h1;
    end
    a_alert_tracks_fault: assert property (alert_output_n == !uv_fault_status)
        else $error("alert output disagrees with fault bit");
    a_fault_bit_holds: assert property (uv_fault_status && !clear_faults |=> uv_fault_status)
        else $error("fault bit dropped without clear");
    a_fault_drops_out: assert property ($rose(uv_fault_status) |-> ##[0:2] !status.output_enable)
        else $error("output still enabled after fault");
    a_ramp_with_on: assert property ($rose(status.output_enable) |-> status.ramp_start)
        else $error("output enabled without ramp start");
    a_fall_ends_out: assert property (status.fall_start |-> !status.output_enable)
        else $error("fall start while output enabled");
    a_pg_off_cleared: assert property (status.off [*3] |-> !status.power_good)
        else $error("power good while output off");
    a_pg_uv_drop: assert property (status.power_good && vout_level < vout_uv_limit
        |-> ##[1:2] !status.power_good)
        else $error("power good kept below undervoltage limit");
    a_retry_gap_min: assert property (status.ramp_start && uv_fault_status
        |-> off_cnt_ff >= RETRY_CYCLES)
        else $error("restart came before retry interval");
    c_ramp: cover property (status.ramp_start);
    c_fall: cover property (status.fall_start);
    c_fault: cover property ($rose(uv_fault_status));
endmodule
bind output_sequencing_uv_response seq_chk #(.CYC_PER_MS(CYC_PER_MS),
    .RETRY_CYCLES(RETRY_CYCLES), .MAX_DELAY_CYCLES(MAX_DELAY_CYCLES)) u_chk (
    .core_clk(core_clk), .rst_n(rst_n), .clear_faults(clear_faults),
    .vout_level(vout_level), .vout_uv_limit(vout_uv_limit), .status(status),
    .alert_output_n(alert_output_n), .uv_fault_status(uv_fault_status));

// *** verif/output_sequencing_uv_response_tb.sv ***
// Self-checking bench of the output sequencer
`timescale 1ns/1ps
module output_sequencing_uv_response_tb;
    localparam int CPM = 4;
    localparam int RT = 50;
    logic core_clk, rst_n, rd_valid, clear_faults, operation_on, control_pin;
    logic vin_uv_pin, other_fault, alert_output_n, uv_fault_status, v;
    logic [7:0] rd_code;
    logic [15:0] rd_data, uv_limit_strap, vout_level, vout_uv_limit, uv_fault_limit, w;
    logic [1:0] phase_mode;
    logic [31:0] multi_ramp_cycles, ramp_cycles;
    seq_pkg::cmd_write_t cmd_wr;
    seq_pkg::seq_status_t status;
    int n_fail = 0;
    int checks_done = 0;
    int mdl[int];
    int n;
    logic [15:0] rd_data_q;
    logic [7:0] codes[7] = '{8'h5A, 8'h5E, 8'h60, 8'h61, 8'h64, 8'h59, 8'h77};
    logic [15:0] lv[4] = '{16'h1200, 16'h0C00, 16'h0400, 16'h1200};
    output_sequencing_uv_response #(.CYC_PER_MS(CPM), .RETRY_CYCLES(32'h32),
        .MAX_DELAY_CYCLES(32'h4E20)) dut (.core_clk, .rst_n, .cmd_wr, .rd_code,
        .rd_data, .rd_valid, .clear_faults, .operation_on, .control_pin, .vin_uv_pin,
        .other_fault, .uv_limit_strap, .vout_level, .vout_uv_limit, .phase_mode,
        .multi_ramp_cycles, .uv_fault_limit, .status, .ramp_cycles,
        .alert_output_n, .uv_fault_status);
    seq_host host (.core_clk, .rd_data, .rd_valid, .cmd_wr, .rd_code);
    function automatic int l11(input logic [15:0] t);
        int e;
        int m;
        e = $signed(t[15:11]);
        m = $signed(t[10:0]);
        if (m < 0) return 0;
        return (e >= 0) ? (m * CPM) << e : (m * CPM) >> -e;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask
    task automatic wait_ev(input int fall, output int cnt);
        cnt = 0;
        do begin
            tick(1);
            cnt++;
        end while ((fall ? status.fall_start : status.ramp_start) !== 1'b1 && cnt < 800);
        chk(cnt < 800, 1);
    endtask
    task automatic rd_all;
        foreach (codes[i]) begin
            host.rd(codes[i], rd_data_q, v);
            chk(rd_data_q, mdl.exists(codes[i]) ? mdl[codes[i]] : 0);
            chk(v, mdl.exists(codes[i]));
        end
        chk(uv_fault_limit, mdl[8'h59]);
    endtask
    task automatic wrap_up;
        $display("Counts: %0d checks, %0d mismatches", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        n_fail++;
        wrap_up();
    end
    initial begin
        {rst_n, clear_faults, operation_on, vin_uv_pin, other_fault} = 5'h00;
        control_pin = 1'b1;
        vout_level = 16'h0000;
        vout_uv_limit = 16'h0800;
        phase_mode = 2'h0;
        multi_ramp_cycles = 32'h25;
        void'($urandom(50));
        uv_limit_strap = 16'($urandom);
        tick(11);
        @(posedge core_clk) rst_n <= 1'b1;
        tick(2);
        mdl = '{8'h5A: 16'h0080, 8'h5E: 16'h0000, 8'h60: 16'hCA80, 8'h61: 16'hCA80,
            8'h64: 16'hCA80, 8'h59: uv_limit_strap};
        rd_all();
        $display("Test reset values done");
        foreach (codes[i]) begin
            w = 16'($urandom);
            if (codes[i] inside {8'h60, 8'h61, 8'h64}) w = {5'h00, 11'($urandom_range(5, 8))};
            host.wr(codes[i], w);
            if (mdl.exists(codes[i])) mdl[codes[i]] = (codes[i] == 8'h5A) ? w[7:0] : w;
        end
        rd_all();
        $display("Test write readback done");
        host.wr(8'h60, 16'h0005);
        host.wr(8'h61, 16'hF810);
        host.wr(8'h64, 16'h0003);
        host.wr(8'h5E, 16'h1000);
        for (int p = 0; p < 2; p++) begin
            @(posedge core_clk) phase_mode <= 2'(p);
            operation_on <= 1'b1;
            wait_ev(0, n);
            chk(n >= l11(16'h0005) && n <= l11(16'h0005) + 6, 1);
            tick(3);
            chk(ramp_cycles, p ? multi_ramp_cycles : l11(16'hF810));
            for (int k = 0; k < 4 && p == 0; k++) begin
                @(posedge core_clk) vout_level <= lv[k];
                tick(4);
                chk(status.power_good, k != 2);
            end
            @(posedge core_clk) operation_on <= 1'b0;
            wait_ev(1, n);
            chk(n >= l11(16'h0003) && n <= l11(16'h0003) + 6, 1);
            tick(1);
            chk({status.output_enable, status.off}, 2'h1);
            tick(10);
        end
        $display("Test delays and power good done");
        host.wr(8'h5A, 16'h0080);
        @(posedge core_clk) operation_on <= 1'b1;
        wait_ev(0, n);
        @(posedge core_clk) vin_uv_pin <= 1'b1;
        tick(6);
        chk({alert_output_n, uv_fault_status, status.output_enable}, 3'h2);
        @(posedge core_clk) vin_uv_pin <= 1'b0;
        tick(40);
        chk({alert_output_n, uv_fault_status, status.output_enable}, 3'h2);
        @(posedge core_clk) clear_faults <= 1'b1;
        @(posedge core_clk) clear_faults <= 1'b0;
        wait_ev(0, n);
        chk({n < 60, alert_output_n, uv_fault_status}, 3'h6);
        @(posedge core_clk) control_pin <= 1'b0;
        tick(40);
        $display("Test latched fault done");
        host.wr(8'h5A, {10'h002, 3'h7, 3'($urandom)});
        @(posedge core_clk) control_pin <= 1'b1;
        wait_ev(0, n);
        @(posedge core_clk) vin_uv_pin <= 1'b1;
        tick(4);
        @(posedge core_clk) vin_uv_pin <= 1'b0;
        wait_ev(0, n);
        chk(n >= RT + 15 && n <= RT + 25, 1);
        chk(uv_fault_status, 1);
        @(posedge core_clk) vin_uv_pin <= 1'b1;
        tick(4);
        @(posedge core_clk) other_fault <= 1'b1;
        vin_uv_pin <= 1'b0;
        tick(150);
        chk(status.output_enable, 0);
        @(posedge core_clk) other_fault <= 1'b0;
        operation_on <= 1'b0;
        $display("Test retry loop done");
        wrap_up();
    end
endmodule
